// >>> hw/sac_consts.svh
`ifndef SAC_CONSTS_SVH
`define SAC_CONSTS_SVH
// Register byte offsets
`define SAC_OFS_CTRL      5'h00
`define SAC_OFS_STATUS    5'h04
`define SAC_OFS_RESULT    5'h08
`define SAC_OFS_IRQ_STAT  5'h0c
`define SAC_OFS_IRQ_MASK  5'h10
// Field positions
`define SAC_CTRL_EXT      0
`define SAC_IRQ_DONE      0
`define SAC_IRQ_ABORT     1
// Reset values
`define SAC_CTRL_RST      32'h0000_0000
`define SAC_MASK_RST      2'h0
// Last analog channel code and the channel codes of the self tests
`define SAC_CH_LAST       4'ha
`define SAC_CH_HALF       4'hb
`define SAC_CH_ZERO       4'hc
`define SAC_CH_FULL       4'hd
// Transfer geometry
`define SAC_ADDR_BITS     4
`define SAC_RES_BITS      10
`define SAC_LONG_XFER     16
// Timing
`define SAC_CLK_NS        100
`define SAC_CONV_NS       44000
`define SAC_CONV_CYC      (`SAC_CONV_NS / `SAC_CLK_NS)
`define SAC_EXT_CONV_CYC  44
`define SAC_CS_FILT_NS    2000
`define SAC_CS_FILT_CYC   (`SAC_CS_FILT_NS / `SAC_CLK_NS)
`endif

// >>> hw/sac_pkg.sv
package sac_pkg;
    // Converter sequence states
    typedef enum logic [1:0] {
        SAC_SHIFT = 2'b00,
        SAC_CONV  = 2'b01,
        SAC_TAIL  = 2'b10
    } sac_state_t;
endpackage : sac_pkg

// >>> hw/sac_adc_ctrl.sv
// Chosen here: the register addresses and register access over Avalon-MM.
`timescale 1ns/100ps
`include "sac_consts.svh"
// Notes on behaviour
// - Internal-clock variant drives done output low at tenth falling shift edge.
// - Done output returns high when conversion ends and result is ready.
// - Address codes 0 to A select analog channels zero to ten.
// - Codes B, C, D convert reference midpoint, lower, upper reference.
// - Self tests yield 200, 000 and 3FF hex on a working converter.
// - Input at or above upper gives all ones; at or below lower, zeros.
// - External-clock variant has no done output, converts in 44 clocks.
// - Shifted-out bits are previous result; shifted-in address picks next.
// - Result leaves MSB first, LSB after ninth fall, low from tenth.
// - Address MSB first, captured on first four rising edges only.
// - Select reasserted during conversion aborts it and keeps prior result.
module sac_adc_ctrl
    import sac_pkg::*;
#(
    parameter int AW       = 12,
    parameter int CONV_CYC = `SAC_CONV_CYC,
    parameter int EXT_CYC  = `SAC_EXT_CONV_CYC,
    parameter int FILT_CYC = `SAC_CS_FILT_CYC
) (
    // Clock and reset
    input  wire logic                ref_clk,
    input  wire logic                resetn,
    // Avalon-MM slave
    input  wire logic [4:0]          address,
    input  wire logic                read,
    input  wire logic                write,
    input  wire logic [31:0]         writedata,
    output logic      [31:0]         readdata,
    output logic                     waitrequest,
    output logic                     irq,
    // Serial port pins
    input  wire logic                chipSelN,
    input  wire logic                shiftClk,
    input  wire logic                serialIn,
    output logic                     serialOut,
    output logic                     serialOutEnN,
    output logic                     convDoneOut,
    input  wire logic                conversionClockIn,
    // Analog levels as digital words
    input  wire logic [10:0][AW-1:0] analogIn,
    input  wire logic [AW-1:0]       lowerReference,
    input  wire logic [AW-1:0]       upperReference
);
    localparam int RW = `SAC_RES_BITS;
    localparam int PW = AW + RW + 2;

    logic [1:0]            rstSync;
    logic                  rstN;
    logic [2:0]            csS, sckS, sdiS, ckS;
    logic [10:0][AW-1:0]   anS1, anS2;
    logic [AW-1:0]         loS1, loS2, hiS1, hiS2;
    logic                  sckRise, sckFall, ckRise;
    logic                  csAct_q;
    logic [7:0]            filtCnt_q;
    logic                  csFallEv;
    sac_state_t            state_q;
    logic [4:0]            riseCnt_q, fallCnt_q;
    logic [3:0]            addrSh_q, chan_q;
    logic [RW-1:0]         outSh_q, result_q;
    logic [AW:0]           vin2_q;
    logic [9:0]            convCnt_q;
    logic                  convEnd, eoc_q, pendReload_q;
    logic                  ext_q;
    logic [1:0]            irqStat_q, irqMask_q;
    logic                  ack_q;
    logic [AW:0]           vinSel;

    // Reset release through two flops
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) rstSync <= 2'b00;
        else         rstSync <= {rstSync[0], 1'b1};
    end
    assign rstN = rstSync[1];

    // Pin synchronisers, third stage for edge finding
    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            csS  <= 3'b111;
            sckS <= 3'b000;
            sdiS <= 3'b000;
            ckS  <= 3'b000;
        end else begin
            csS  <= {csS[1:0], chipSelN};
            sckS <= {sckS[1:0], shiftClk};
            sdiS <= {sdiS[1:0], serialIn};
            ckS  <= {ckS[1:0], conversionClockIn};
        end
    end
    assign sckRise = sckS[1] & ~sckS[2];
    assign sckFall = ~sckS[1] & sckS[2];
    assign ckRise  = ckS[1] & ~ckS[2];

    // Analog words pass two flops
    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            anS1 <= '0;
            anS2 <= '0;
            loS1 <= '0;
            loS2 <= '0;
            hiS1 <= '0;
            hiS2 <= '0;
        end else begin
            anS1 <= analogIn;
            anS2 <= anS1;
            loS1 <= lowerReference;
            loS2 <= loS1;
            hiS1 <= upperReference;
            hiS2 <= hiS1;
        end
    end

    // Select glitch filter: level must hold before it counts
    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            csAct_q   <= 1'b0;
            filtCnt_q <= 8'h00;
        end else if (csAct_q == csS[1]) begin
            if (filtCnt_q == 8'(FILT_CYC - 1)) begin
                csAct_q   <= ~csS[1];
                filtCnt_q <= 8'h00;
            end else begin
                filtCnt_q <= filtCnt_q + 8'h01;
            end
        end else begin
            filtCnt_q <= 8'h00;
        end
    end
    assign csFallEv = (csAct_q == csS[1])
                      && (filtCnt_q == 8'(FILT_CYC - 1)) && csS[1] == 1'b0;

    // Level to convert: channel or self-test reference, doubled
    always_comb begin
        unique case (addrSh_q)
            `SAC_CH_HALF: vinSel = {1'b0, loS2} + {1'b0, hiS2};
            `SAC_CH_ZERO: vinSel = {loS2, 1'b0};
            `SAC_CH_FULL: vinSel = {hiS2, 1'b0};
            default: begin
                if (addrSh_q <= `SAC_CH_LAST)
                    vinSel = {anS2[addrSh_q], 1'b0};
                else
                    vinSel = '0;
            end
        endcase
    end

    // Successive approximation against the doubled reference ladder
    function automatic logic [RW-1:0] sar(input logic [AW:0] v2,
                                          input logic [AW-1:0] lo,
                                          input logic [AW-1:0] hi);
        logic [RW-1:0] code;
        logic [RW-1:0] trial;
        logic [PW-1:0] thr;
        logic [PW-1:0] lhs;
        code = '0;
        lhs  = PW'(v2) << RW;
        for (int b = RW - 1; b >= 0; b--) begin
            trial = code | (RW'(1) << b);
            thr = (PW'(lo) << (RW + 1))
                  + ((PW'(hi) - PW'(lo)) * PW'(trial) << 1);
            if (hi > lo && lhs >= thr) code = trial;
            if (hi <= lo && v2 >= {hi, 1'b0}) code = trial;
        end
        return code;
    endfunction : sar

    // End of conversion: own clock or 44 conversion clocks
    assign convEnd = (state_q == SAC_CONV)
                     && (ext_q ? (convCnt_q == 10'(EXT_CYC - 1)) && ckRise
                               : (convCnt_q == 10'(CONV_CYC - 1)));

    // Conversion timer
    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) convCnt_q <= 10'h000;
        else if (state_q != SAC_CONV) convCnt_q <= 10'h000;
        else if (!ext_q || ckRise) convCnt_q <= convCnt_q + 10'h001;
    end

    // Serial port and conversion sequence
    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            state_q      <= SAC_SHIFT;
            riseCnt_q    <= 5'h00;
            fallCnt_q    <= 5'h00;
            addrSh_q     <= 4'h0;
            chan_q       <= 4'h0;
            outSh_q      <= '0;
            result_q     <= '0;
            vin2_q       <= '0;
            eoc_q        <= 1'b1;
            pendReload_q <= 1'b0;
        end else if (csFallEv) begin
            // New select restarts the port; conversion in flight dropped
            state_q      <= SAC_SHIFT;
            riseCnt_q    <= 5'h00;
            fallCnt_q    <= 5'h00;
            outSh_q      <= result_q;
            eoc_q        <= 1'b1;
            pendReload_q <= 1'b0;
        end else if (convEnd) begin
            result_q <= sar(vin2_q, loS2, hiS2);
            eoc_q    <= 1'b1;
            if (csAct_q && (fallCnt_q == 5'(RW)
                            || fallCnt_q == 5'(`SAC_LONG_XFER))) begin
                state_q   <= SAC_SHIFT;
                riseCnt_q <= 5'h00;
                fallCnt_q <= 5'h00;
                outSh_q   <= sar(vin2_q, loS2, hiS2);
            end else begin
                state_q      <= csAct_q ? SAC_TAIL : SAC_SHIFT;
                pendReload_q <= csAct_q;
            end
        end else if (csAct_q) begin
            if (sckRise && riseCnt_q != 5'h1f) begin
                riseCnt_q <= riseCnt_q + 5'h01;
                if (state_q == SAC_SHIFT
                    && riseCnt_q < 5'(`SAC_ADDR_BITS))
                    addrSh_q <= {addrSh_q[2:0], sdiS[1]};
            end
            if (sckFall) begin
                fallCnt_q <= fallCnt_q + 5'h01;
                outSh_q   <= {outSh_q[RW-2:0], 1'b0};
                if (state_q == SAC_SHIFT && fallCnt_q == 5'(RW - 1)) begin
                    state_q <= SAC_CONV;
                    chan_q  <= addrSh_q;
                    vin2_q  <= vinSel;                     // sample ends here
                    eoc_q   <= 1'b0;
                end
                if (state_q == SAC_TAIL
                    && fallCnt_q == 5'(`SAC_LONG_XFER - 1)) begin
                    state_q      <= SAC_SHIFT;
                    riseCnt_q    <= 5'h00;
                    fallCnt_q    <= 5'h00;
                    outSh_q      <= result_q;
                    pendReload_q <= 1'b0;
                end
            end
        end else if (state_q == SAC_TAIL) begin
            state_q      <= SAC_SHIFT;
            pendReload_q <= 1'b0;
        end
    end

    // Pin drive: data from flops, enable low while driving
    assign serialOut    = outSh_q[RW-1];
    assign serialOutEnN = ~csAct_q;
    assign convDoneOut  = ext_q ? 1'b1 : eoc_q;

    // Bus handshake: one wait cycle per access
    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) ack_q <= 1'b0;
        else       ack_q <= (read | write) & ~ack_q;
    end
    assign waitrequest = (read | write) & ~ack_q;

    // Control register
    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) ext_q <= 1'(`SAC_CTRL_RST >> `SAC_CTRL_EXT);
        else if (write && ack_q && address == `SAC_OFS_CTRL)
            ext_q <= writedata[`SAC_CTRL_EXT];
    end

    // Sticky events, set wins over write-one-to-clear
    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            irqStat_q <= 2'h0;
            irqMask_q <= `SAC_MASK_RST;
        end else begin
            if (write && ack_q && address == `SAC_OFS_IRQ_MASK)
                irqMask_q <= writedata[1:0];
            irqStat_q <= (irqStat_q
                          & ~((write && ack_q
                               && address == `SAC_OFS_IRQ_STAT)
                              ? writedata[1:0] : 2'h0))
                         | {csFallEv && state_q == SAC_CONV, convEnd};
        end
    end
    assign irq = |(irqStat_q & irqMask_q);

    // Read data, zero for unmapped addresses
    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) readdata <= 32'h0000_0000;
        else if (read && !ack_q) begin
            unique case (address)
                `SAC_OFS_CTRL:     readdata <= {31'h0, ext_q};
                `SAC_OFS_STATUS:   readdata <= {20'h0, chan_q,
                                                2'h0, csAct_q, eoc_q,
                                                2'(state_q), pendReload_q,
                                                state_q == SAC_CONV};
                `SAC_OFS_RESULT:   readdata <= {22'h0, result_q};
                `SAC_OFS_IRQ_STAT: readdata <= {30'h0, irqStat_q};
                `SAC_OFS_IRQ_MASK: readdata <= {30'h0, irqMask_q};
                default:           readdata <= 32'h0000_0000;
            endcase
        end
    end

    // Assertions
    AST_EOC_LOW: assert property (@(posedge ref_clk) disable iff (!rstN)
        (csAct_q && !csFallEv && sckFall && state_q == SAC_SHIFT
         && fallCnt_q == 5'(RW - 1) && !ext_q) |=> !convDoneOut)
        else $error("done output not low after tenth fall");
    AST_EOC_HIGH: assert property (@(posedge ref_clk) disable iff (!rstN)
        (convEnd && !csFallEv) |=> convDoneOut && eoc_q)
        else $error("done output not high at conversion end");
    AST_RESULT_NEW: assert property (@(posedge ref_clk) disable iff (!rstN)
        (convEnd && !csFallEv) |=> result_q == sar(vin2_q, loS2, hiS2))
        else $error("result not updated at conversion end");
    AST_INT_TIME: assert property (@(posedge ref_clk) disable iff (!rstN)
        (!ext_q && state_q == SAC_CONV && $past(state_q) != SAC_CONV)
        |-> ##[1:CONV_CYC] (state_q != SAC_CONV || csFallEv))
        else $error("internal conversion overran");
    AST_EXT_NODONE: assert property (@(posedge ref_clk) disable iff (!rstN)
        ext_q |-> convDoneOut)
        else $error("done output moved in external mode");
    AST_DOUT_LOW: assert property (@(posedge ref_clk) disable iff (!rstN)
        (state_q == SAC_CONV && fallCnt_q >= 5'(RW)) |-> !serialOut)
        else $error("data output not low after tenth fall");
    AST_ADDR_HOLD: assert property (@(posedge ref_clk) disable iff (!rstN)
        (riseCnt_q >= 5'(`SAC_ADDR_BITS) && !csFallEv && !convEnd)
        |=> $stable(addrSh_q))
        else $error("address changed after fourth rise");
    AST_ABORT: assert property (@(posedge ref_clk) disable iff (!rstN)
        (csFallEv && state_q == SAC_CONV)
        |=> $stable(result_q) && state_q == SAC_SHIFT
            && outSh_q == result_q)
        else $error("abort did not keep prior result");
    AST_OE: assert property (@(posedge ref_clk) disable iff (!rstN)
        !csAct_q |-> serialOutEnN)
        else $error("data output driven while deselected");
    COV_CONV: cover property (@(posedge ref_clk) disable iff (!rstN)
        convEnd && !ext_q);
    COV_EXT: cover property (@(posedge ref_clk) disable iff (!rstN)
        convEnd && ext_q);
    COV_ABORT: cover property (@(posedge ref_clk) disable iff (!rstN)
        csFallEv && state_q == SAC_CONV);
    COV_TAIL: cover property (@(posedge ref_clk) disable iff (!rstN)
        state_q == SAC_TAIL && sckFall);
endmodule : sac_adc_ctrl

// >>> bench/sac_spi_master.sv
`timescale 1ns/100ps
module sac_spi_master (
    // Clock
    input  wire logic ref_clk,
    // Serial pins towards the converter
    output logic      chipSelN,
    output logic      shiftClk,
    output logic      serialIn,
    input  wire logic serialOut,
    input  wire logic serialOutEnN
);
    logic idle;

    // Pins at rest, shift clock stands still low
    initial begin
        chipSelN = 1'b1;
        shiftClk = 1'b0;
        serialIn = 1'b0;
        idle     = 1'b1;
    end

    // Unused data line toggles so no stale level lingers
    always @(posedge ref_clk) begin
        if (idle) serialIn <= ~serialIn;
    end

    // One frame: 8 ref_clk per shift clock, data read before each fall
    task automatic xfer(input logic [3:0] a, input int n, input logic rel,
                        output logic [15:0] rx);
        int i;
        @(posedge ref_clk);
        chipSelN <= 1'b0;
        idle     <= 1'b0;
        repeat (10) @(posedge ref_clk);
        rx = 16'h0000;
        for (i = 0; i < n; i++) begin
            // Address MSB first, junk after the fourth bit
            serialIn <= (i < 4) ? a[3 - i] : 1'($urandom_range(1));
            repeat (4) @(posedge ref_clk);
            shiftClk <= 1'b1;
            repeat (4) @(posedge ref_clk);
            // Released line reads as unknown, never as a stale bit
            rx[15 - i] = serialOutEnN ? 1'bx : serialOut;
            shiftClk <= 1'b0;
        end
        repeat (2) @(posedge ref_clk);
        if (rel) begin
            chipSelN <= 1'b1;
            idle     <= 1'b1;
        end
    endtask : xfer
endmodule : sac_spi_master

// >>> bench/tb.sv
`timescale 1ns/100ps
`include "sac_consts.svh"
module tb;
    localparam int AW = 12;
    logic                ref_clk, resetn, read, write, conversionClockIn;
    logic [4:0]          address;
    logic [31:0]         writedata, readdata, rd;
    logic                waitrequest, irq, chipSelN, shiftClk, serialIn;
    logic                serialOut, serialOutEnN, convDoneOut, hasPrev;
    logic [10:0][AW-1:0] analogIn;
    logic [AW-1:0]       lowerReference, upperReference;
    logic [15:0]         rx;
    logic [9:0]          prevRes, expRes;
    logic [1:0]          irqMask;
    int                  numErrors, nCompared, cyc, i, k;

    sac_adc_ctrl #(.AW(AW), .CONV_CYC(60), .EXT_CYC(44), .FILT_CYC(3))
    sac_adc_ctrl_i (.ref_clk(ref_clk), .resetn(resetn), .address(address),
        .read(read), .write(write), .writedata(writedata),
        .readdata(readdata), .waitrequest(waitrequest), .irq(irq),
        .chipSelN(chipSelN), .shiftClk(shiftClk), .serialIn(serialIn),
        .serialOut(serialOut), .serialOutEnN(serialOutEnN),
        .convDoneOut(convDoneOut), .conversionClockIn(conversionClockIn),
        .analogIn(analogIn), .lowerReference(lowerReference),
        .upperReference(upperReference));

    sac_spi_master sac_spi_master_i (.ref_clk(ref_clk), .chipSelN(chipSelN),
        .shiftClk(shiftClk), .serialIn(serialIn), .serialOut(serialOut),
        .serialOutEnN(serialOutEnN));

    // System clock and free-running conversion clock
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    initial begin
        conversionClockIn = 1'b0;
        forever #300 conversionClockIn = ~conversionClockIn;
    end

    // Hang guard
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            numErrors++;
            summarize();
        end
    end

    task summarize;
        $display("compared %0d mismatches %0d", nCompared, numErrors);
        if (numErrors == 0 && nCompared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : summarize

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        nCompared++;
        if (g !== e) begin
            numErrors++;
            $display("MISMATCH %s exp %h got %h", nm, e, g);
        end
    endtask : chk

    // Code compare, one step of slack for rounding on every code but 000 and 3FF
    task automatic chkNear(input string nm, input logic [9:0] e,
                           input logic [9:0] g, input logic tol);
        nCompared++;
        if (!(g === e || (tol && (g === e + 10'h1 || g === e - 10'h1)))) begin
            numErrors++;
            $display("MISMATCH %s exp %h got %h", nm, e, g);
        end
    endtask : chkNear

    // Avalon access, held until waitrequest is seen low
    task automatic bus(input logic [4:0] a, input logic wr,
                       input logic [31:0] d, output logic [31:0] q);
        @(posedge ref_clk);
        address   <= a;
        writedata <= d;
        write     <= wr;
        read      <= ~wr;
        do @(posedge ref_clk); while (waitrequest !== 1'b0);
        q = readdata;
        read  <= 1'b0;
        write <= 1'b0;
    endtask : bus

    function automatic logic [9:0] expCode(input logic [3:0] c);
        logic [AW-1:0] x;
        case (c)
            4'hb: return 10'h200;
            4'hc: return 10'h000;
            4'hd: return 10'h3ff;
            default: begin
                x = analogIn[c];
                if (x >= upperReference) return 10'h3ff;
                if (x <= lowerReference) return 10'h000;
                return 10'((32'(x - lowerReference) * 1024)
                    / 32'(upperReference - lowerReference));
            end
        endcase
    endfunction : expCode

    // One frame then the conversion it starts
    task automatic conv(input logic [3:0] c, input int n, input logic ext);
        int t;
        sac_spi_master_i.xfer(c, n, 1'b1, rx);
        expRes = expCode(c);
        // Tenth fall reaches the port two clocks after the pin
        repeat (2) @(posedge ref_clk);
        chk("doneOut", {31'h0, ext}, {31'h0, convDoneOut});
        if (hasPrev) chk("serial", {22'h0, prevRes}, {22'h0, rx[15:6]});
        if (n == 16) chk("tail", 32'h0, {26'h0, rx[5:0]});
        if (ext) begin
            // Long frame has already spent about eight conversion clocks
            repeat ((n == 16) ? 33 : 42) @(posedge conversionClockIn);
            bus(`SAC_OFS_STATUS, 1'b0, 32'h0, rd);
            chk("busy42", 32'h1, {31'h0, rd[0]});
            repeat (4) @(posedge conversionClockIn);
            repeat (4) @(posedge ref_clk);
            bus(`SAC_OFS_STATUS, 1'b0, 32'h0, rd);
            chk("busy46", 32'h0, {31'h0, rd[0]});
        end else begin
            t = 0;
            while (convDoneOut !== 1'b1 && t < 500) begin
                @(posedge ref_clk);
                t++;
            end
            chk("doneRise", 32'h1, {31'h0, convDoneOut});
        end
        bus(`SAC_OFS_RESULT, 1'b0, 32'h0, rd);
        chkNear("result", expRes, rd[9:0], expRes != 10'h0 && expRes != 10'h3ff);
        prevRes = rd[9:0];
        hasPrev = 1'b1;
        bus(`SAC_OFS_STATUS, 1'b0, 32'h0, rd);
        chk("lastCh", {28'h0, c}, {28'h0, rd[11:8]});
        chk("irqDone", {31'h0, irqMask[0]}, {31'h0, irq});
        bus(`SAC_OFS_IRQ_STAT, 1'b0, 32'h0, rd);
        chk("statDone", 32'h1, {31'h0, rd[0]});
        bus(`SAC_OFS_IRQ_STAT, 1'b1, 32'h1, rd);
        // Clear lands at the accepting edge, seen one clock later
        @(posedge ref_clk);
        chk("irqClr", 32'h0, {31'h0, irq});
    endtask : conv

    initial begin
        resetn = 1'b0; read = 1'b0; write = 1'b0; address = 5'h00;
        writedata = 32'h0; numErrors = 0; nCompared = 0; cyc = 0;
        hasPrev = 1'b0; irqMask = 2'h1;
        k = $urandom(32'h8e4d1e18);
        lowerReference = 12'h100;
        upperReference = 12'he00;
        for (i = 0; i < 11; i++) analogIn[i] = 12'($urandom);
        // Clamp corners at and beyond both references
        analogIn[0] = 12'hfff; analogIn[1] = 12'h050;
        analogIn[2] = 12'he00; analogIn[3] = 12'h100;
        repeat (12) @(posedge ref_clk);
        resetn <= 1'b1;
        repeat (3) @(posedge ref_clk);
        chk("enRst", 32'h1, {31'h0, serialOutEnN});
        chk("doneRst", 32'h1, {31'h0, convDoneOut});
        bus(`SAC_OFS_CTRL, 1'b0, 32'h0, rd);
        chk("ctrlRst", `SAC_CTRL_RST, rd);
        bus(`SAC_OFS_IRQ_MASK, 1'b0, 32'h0, rd);
        chk("maskRst", {30'h0, `SAC_MASK_RST}, rd);
        bus(5'h14, 1'b1, 32'hffffffff, rd);
        bus(5'h14, 1'b0, 32'h0, rd);
        chk("unmapped", 32'h0, rd);
        bus(`SAC_OFS_IRQ_MASK, 1'b1, 32'h1, rd);
        // Every channel and self test, both frame lengths
        for (k = 0; k < 14; k++) conv(4'(k), (k % 2) ? 16 : 10, 1'b0);
        for (k = 0; k < 6; k++) begin
            analogIn[5] <= 12'($urandom);
            conv(4'($urandom_range(13)), 10, 1'b0);
        end
        // Done event masked off
        irqMask = 2'h0;
        bus(`SAC_OFS_IRQ_MASK, 1'b1, 32'h0, rd);
        conv(4'h5, 10, 1'b0);
        // Reselect mid-conversion aborts, prior result kept
        sac_spi_master_i.xfer(4'h7, 10, 1'b1, rx);
        repeat (8) @(posedge ref_clk);
        conv(4'h6, 10, 1'b0);
        bus(`SAC_OFS_IRQ_MASK, 1'b1, 32'h2, rd);
        repeat (2) @(posedge ref_clk);
        chk("irqAbort", 32'h1, {31'h0, irq});
        bus(`SAC_OFS_IRQ_STAT, 1'b1, 32'h2, rd);
        @(posedge ref_clk);
        chk("irqAbClr", 32'h0, {31'h0, irq});
        // Externally clocked variant
        irqMask = 2'h0;
        bus(`SAC_OFS_CTRL, 1'b1, 32'h1, rd);
        conv(4'hd, 10, 1'b1);
        conv(4'h2, 16, 1'b1);
        summarize();
    end
endmodule : tb
